// ===== rtl/scc_codec_map.vh
// constants for the special character 8b/10b codec
`ifndef SCC_CODEC_MAP_VH
`define SCC_CODEC_MAP_VH

// ============================================================
// character and code class index widths
`define SCC_BYTE_W 8
`define SCC_CHAR_W 10
`define SCC_KIDX_W 5

// ============================================================
// encoder code classes (0 to 11 are the twelve k-characters)
`define SCC_KIDX_K285 5'h05
`define SCC_KIDX_EOF 5'h0c
`define SCC_KIDX_VTS 5'h0d
`define SCC_KIDX_NEGK 5'h0e
`define SCC_KIDX_POSK 5'h0f
`define SCC_KIDX_RDV 5'h10
`define SCC_KIDX_RSVD 5'h1f
`define SCC_KIDX_LAST_K 5'h0b

// ============================================================
// special codes of the default and alternate code sets
`define SCC_CODE_EOF 8'h22
`define SCC_CODE_VTS 8'he0
`define SCC_CODE_NEGK 8'he1
`define SCC_CODE_POSK 8'he2
`define SCC_CODE_RDV 8'he4
`define SCC_CODE_K285 8'h05
`define SCC_CODE_ALT_K28 5'h1c
`define SCC_CODE_ALT_K237 8'hf7
`define SCC_CODE_ALT_K277 8'hfb
`define SCC_CODE_ALT_K297 8'hfd
`define SCC_CODE_ALT_K307 8'hfe

// ============================================================
// fixed ten-bit patterns and the six-bit K28 prefix, bit 9 is a, bit 0 is j
`define SCC_K285_NEG 10'h0fa
`define SCC_K285_POS 10'h305
`define SCC_VTS_RDM 10'h278
`define SCC_RDV_RDM 10'h375
`define SCC_K28_6B 6'h0f

// ============================================================
// receive status values
`define SCC_ST_DATA 3'h0
`define SCC_ST_SPECIAL 3'h1
`define SCC_ST_RD_VIOL 3'h2
`define SCC_ST_CODE_VIOL 3'h3

// ============================================================
// reset value and code set select bit
`define SCC_RD_RST 1'h0
`define SCC_CODE_SET_ALT_BIT 0

// ============================================================
// bit positions
`define SCC_EOF_MOD_BIT 5

`endif

// ===== rtl/scc_codec.v
// special character 8b/10b encoder and decoder for one channel
`timescale 1ns/1ns
`include "scc_codec_map.vh"

module scc_codec (
	input wire clk_sys,
	input wire rstn,
	input wire tx_valid,
	input wire tx_special,
	input wire [7:0] tx_data,
	input wire tx_encoded_mode,
	output reg [9:0] tx_char_r,
	output reg tx_rd_r,
	input wire rx_valid,
	input wire [9:0] rx_char,
	input wire [1:0] decode_code_set_select,
	input wire framer_enable,
	output reg rx_valid_r,
	output reg [7:0] rx_data_r,
	output reg rx_special_r,
	output reg [2:0] rx_status_r,
	output reg rx_rd_r,
	output reg rx_align_r
);

// ============================================================
// coding functions
function [9:0] scc_enc_data;
	input [7:0] d;
	input rd;
	reg [5:0] c6;
	reg [3:0] c4;
	reg [2:0] w6, w4;
	reg rd6, a7;
	begin
		case (d[4:0])
			5'd0: c6 = 6'b100111;
			5'd1: c6 = 6'b011101;
			5'd2: c6 = 6'b101101;
			5'd3: c6 = 6'b110001;
			5'd4: c6 = 6'b110101;
			5'd5: c6 = 6'b101001;
			5'd6: c6 = 6'b011001;
			5'd7: c6 = 6'b111000;
			5'd8: c6 = 6'b111001;
			5'd9: c6 = 6'b100101;
			5'd10: c6 = 6'b010101;
			5'd11: c6 = 6'b110100;
			5'd12: c6 = 6'b001101;
			5'd13: c6 = 6'b101100;
			5'd14: c6 = 6'b011100;
			5'd15: c6 = 6'b010111;
			5'd16: c6 = 6'b011011;
			5'd17: c6 = 6'b100011;
			5'd18: c6 = 6'b010011;
			5'd19: c6 = 6'b110010;
			5'd20: c6 = 6'b001011;
			5'd21: c6 = 6'b101010;
			5'd22: c6 = 6'b011010;
			5'd23: c6 = 6'b111010;
			5'd24: c6 = 6'b110011;
			5'd25: c6 = 6'b100110;
			5'd26: c6 = 6'b010110;
			5'd27: c6 = 6'b110110;
			5'd28: c6 = 6'b001110;
			5'd29: c6 = 6'b101110;
			5'd30: c6 = 6'b011110;
			default: c6 = 6'b101011;
		endcase
		w6 = {2'h0, c6[0]} + {2'h0, c6[1]} + {2'h0, c6[2]} + {2'h0, c6[3]} + {2'h0, c6[4]} + {2'h0, c6[5]};
		if (rd && (w6 != 3'd3 || d[4:0] == 5'd7)) begin
			c6 = ~c6;
		end
		rd6 = (w6 != 3'd3) ? ~rd : rd;
		a7 = (!rd6 && (d[4:0] == 5'd17 || d[4:0] == 5'd18 || d[4:0] == 5'd20)) ||
			(rd6 && (d[4:0] == 5'd11 || d[4:0] == 5'd13 || d[4:0] == 5'd14));
		case (d[7:5])
			3'd0: c4 = 4'b1011;
			3'd1: c4 = 4'b1001;
			3'd2: c4 = 4'b0101;
			3'd3: c4 = 4'b1100;
			3'd4: c4 = 4'b1101;
			3'd5: c4 = 4'b1010;
			3'd6: c4 = 4'b0110;
			default: c4 = a7 ? 4'b0111 : 4'b1110;
		endcase
		w4 = {2'h0, c4[0]} + {2'h0, c4[1]} + {2'h0, c4[2]} + {2'h0, c4[3]};
		if (rd6 && (w4 != 3'd2 || d[7:5] == 3'd3)) begin
			c4 = ~c4;
		end
		scc_enc_data = {c6, c4};
	end
endfunction

// negative-disparity form; the positive form is its complement
function [9:0] scc_k_rdm;
	input [4:0] idx;
	begin
		case (idx)
			5'd0: scc_k_rdm = {`SCC_K28_6B, 4'b0100};
			5'd1: scc_k_rdm = {`SCC_K28_6B, 4'b1001};
			5'd2: scc_k_rdm = {`SCC_K28_6B, 4'b0101};
			5'd3: scc_k_rdm = {`SCC_K28_6B, 4'b0011};
			5'd4: scc_k_rdm = {`SCC_K28_6B, 4'b0010};
			5'd5: scc_k_rdm = {`SCC_K28_6B, 4'b1010};
			5'd6: scc_k_rdm = {`SCC_K28_6B, 4'b0110};
			5'd7: scc_k_rdm = {`SCC_K28_6B, 4'b1000};
			5'd8: scc_k_rdm = 10'b1110101000;
			5'd9: scc_k_rdm = 10'b1101101000;
			5'd10: scc_k_rdm = 10'b1011101000;
			default: scc_k_rdm = 10'b0111101000;
		endcase
	end
endfunction

// ones above five drive disparity positive, below five negative
function scc_rd_after;
	input [9:0] c;
	input rd;
	reg [3:0] w;
	integer b;
	begin
		w = 4'h0;
		for (b = 0; b < 10; b = b + 1) begin
			w = w + {3'h0, c[b]};
		end
		scc_rd_after = (w > 4'd5) ? 1'b1 : ((w < 4'd5) ? 1'b0 : rd);
	end
endfunction

function [4:0] scc_code_class;
	input [7:0] d;
	begin
		if (d <= {3'h0, `SCC_KIDX_LAST_K}) begin
			scc_code_class = d[4:0];
		end else if (d[4:0] == `SCC_CODE_ALT_K28) begin
			scc_code_class = {2'h0, d[7:5]};
		end else begin
			case (d)
				`SCC_CODE_ALT_K237: scc_code_class = 5'd8;
				`SCC_CODE_ALT_K277: scc_code_class = 5'd9;
				`SCC_CODE_ALT_K297: scc_code_class = 5'd10;
				`SCC_CODE_ALT_K307: scc_code_class = 5'd11;
				`SCC_CODE_EOF: scc_code_class = `SCC_KIDX_EOF;
				`SCC_CODE_VTS: scc_code_class = `SCC_KIDX_VTS;
				`SCC_CODE_NEGK: scc_code_class = `SCC_KIDX_NEGK;
				`SCC_CODE_POSK: scc_code_class = `SCC_KIDX_POSK;
				`SCC_CODE_RDV: scc_code_class = `SCC_KIDX_RDV;
				default: scc_code_class = `SCC_KIDX_RSVD;
			endcase
		end
	end
endfunction

function [7:0] scc_k_code;
	input [4:0] idx;
	input alt;
	begin
		if (!alt) begin
			scc_k_code = {3'h0, idx};
		end else if (idx < 5'd8) begin
			scc_k_code = {idx[2:0], `SCC_CODE_ALT_K28};
		end else begin
			case (idx)
				5'd8: scc_k_code = `SCC_CODE_ALT_K237;
				5'd9: scc_k_code = `SCC_CODE_ALT_K277;
				5'd10: scc_k_code = `SCC_CODE_ALT_K297;
				default: scc_k_code = `SCC_CODE_ALT_K307;
			endcase
		end
	end
endfunction

// ============================================================
// transmit encoder
reg eof_pending_r, eof_pending_nxt;
reg [9:0] tx_char_nxt, tx_k285;
reg [7:0] tx_byte;
reg [4:0] tx_class;

always @* begin
	tx_byte = tx_data;
	tx_class = scc_code_class(tx_data);
	eof_pending_nxt = 1'b0;
	tx_k285 = tx_rd_r ? `SCC_K285_POS : `SCC_K285_NEG;
	tx_char_nxt = tx_k285;
	if (tx_valid && !tx_special) begin
		// low bit of hgf from disparity
		if (eof_pending_r) begin
			tx_byte[`SCC_EOF_MOD_BIT] = ~tx_rd_r;
		end
		tx_char_nxt = scc_enc_data(tx_byte, tx_rd_r);
	end else if (tx_valid) begin
		if (tx_class <= `SCC_KIDX_LAST_K) begin
			tx_char_nxt = tx_rd_r ? ~scc_k_rdm(tx_class) : scc_k_rdm(tx_class);
		end else begin
			case (tx_class)
				`SCC_KIDX_EOF: eof_pending_nxt = 1'b1;
				`SCC_KIDX_VTS: tx_char_nxt = tx_rd_r ? ~`SCC_VTS_RDM : `SCC_VTS_RDM;
				`SCC_KIDX_NEGK: tx_char_nxt = `SCC_K285_NEG;
				`SCC_KIDX_POSK: tx_char_nxt = `SCC_K285_POS;
				`SCC_KIDX_RDV: tx_char_nxt = !tx_encoded_mode ? tx_k285 :
					(tx_rd_r ? ~`SCC_RDV_RDM : `SCC_RDV_RDM);
				default: tx_char_nxt = tx_k285;
			endcase
		end
	end
end

always @(posedge clk_sys) begin
	if (!rstn) begin
		tx_char_r <= `SCC_K285_NEG;
		tx_rd_r <= `SCC_RD_RST;
		eof_pending_r <= 1'b0;
	end else begin
		tx_char_r <= tx_char_nxt;
		tx_rd_r <= scc_rd_after(tx_char_nxt, tx_rd_r);
		eof_pending_r <= eof_pending_nxt;
	end
end

// ============================================================
// receive decoder
// full compare against every table entry; the entries fold to constants,
// so this costs comparators rather than a hand-kept inverse table
reg dat_ok, dat_bad, k_ok, k_bad;
reg [7:0] dat_ok_val, dat_bad_val, rx_data_nxt;
reg [4:0] k_ok_idx, k_bad_idx;
reg rx_special_nxt;
reg [2:0] rx_status_nxt;
reg [9:0] rx_exp;
integer i;

always @* begin
	dat_ok = 1'b0;
	dat_bad = 1'b0;
	dat_ok_val = 8'h00;
	dat_bad_val = 8'h00;
	k_ok = 1'b0;
	k_bad = 1'b0;
	k_ok_idx = 5'h00;
	k_bad_idx = 5'h00;
	rx_exp = 10'h000;
	for (i = 0; i < 256; i = i + 1) begin
		rx_exp = scc_enc_data(i[7:0], rx_rd_r);
		if (rx_char == rx_exp) begin
			dat_ok = 1'b1;
			dat_ok_val = i[7:0];
		end
		rx_exp = scc_enc_data(i[7:0], ~rx_rd_r);
		if (rx_char == rx_exp) begin
			dat_bad = 1'b1;
			dat_bad_val = i[7:0];
		end
	end
	for (i = 0; i <= `SCC_KIDX_LAST_K; i = i + 1) begin
		rx_exp = rx_rd_r ? ~scc_k_rdm(i[4:0]) : scc_k_rdm(i[4:0]);
		if (rx_char == rx_exp) begin
			k_ok = 1'b1;
			k_ok_idx = i[4:0];
		end
		if (rx_char == ~rx_exp) begin
			k_bad = 1'b1;
			k_bad_idx = i[4:0];
		end
	end
	rx_special_nxt = 1'b1;
	rx_status_nxt = `SCC_ST_SPECIAL;
	if (k_ok) begin
		rx_data_nxt = scc_k_code(k_ok_idx, decode_code_set_select[`SCC_CODE_SET_ALT_BIT]);
	end else if (k_bad && k_bad_idx == `SCC_KIDX_K285) begin
		rx_data_nxt = rx_rd_r ? `SCC_CODE_NEGK : `SCC_CODE_POSK;
	end else if (dat_ok) begin
		rx_data_nxt = dat_ok_val;
		rx_special_nxt = 1'b0;
		rx_status_nxt = `SCC_ST_DATA;
	end else if (k_bad || dat_bad) begin
		rx_data_nxt = `SCC_CODE_RDV;
		rx_status_nxt = `SCC_ST_RD_VIOL;
	end else begin
		rx_data_nxt = `SCC_CODE_VTS;
		rx_status_nxt = `SCC_ST_CODE_VIOL;
	end
end

always @(posedge clk_sys) begin
	if (!rstn) begin
		rx_valid_r <= 1'b0;
		rx_data_r <= 8'h00;
		rx_special_r <= 1'b0;
		rx_status_r <= `SCC_ST_DATA;
		rx_rd_r <= `SCC_RD_RST;
		rx_align_r <= 1'b0;
	end else begin
		rx_valid_r <= rx_valid;
		rx_align_r <= rx_valid && framer_enable &&
			(rx_char == `SCC_K285_NEG || rx_char == `SCC_K285_POS);
		if (rx_valid) begin
			rx_data_r <= rx_data_nxt;
			rx_special_r <= rx_special_nxt;
			rx_status_r <= rx_status_nxt;
			rx_rd_r <= scc_rd_after(rx_char, rx_rd_r);
		end
	end
end

endmodule // scc_codec

// ===== tb/scc_codec_checker.sv
// assertions on the ports of the special character codec
`timescale 1ns/1ns
`include "scc_codec_map.vh"
module scc_codec_checker (
	input wire clk_sys,
	input wire rstn,
	input wire tx_valid,
	input wire tx_special,
	input wire [7:0] tx_data,
	input wire tx_encoded_mode,
	input wire [9:0] tx_char_r,
	input wire tx_rd_r,
	input wire rx_valid,
	input wire [9:0] rx_char,
	input wire [1:0] decode_code_set_select,
	input wire framer_enable,
	input wire rx_valid_r,
	input wire [7:0] rx_data_r,
	input wire rx_special_r,
	input wire [2:0] rx_status_r,
	input wire rx_rd_r,
	input wire rx_align_r
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	// ============================================================
	// transmit
	sequence s_sc(c);
		tx_valid && tx_special && tx_data == c;
	endsequence
	sequence s_dat;
		tx_valid && !tx_special;
	endsequence
	a_fill_when_idle: assert property (!tx_valid |=> tx_char_r == ($past(tx_rd_r) ? `SCC_K285_POS : `SCC_K285_NEG))
		else $error("idle fill wrong");
	a_eof_k_rd: assert property (s_sc(8'h22) |=> tx_char_r == ($past(tx_rd_r) ? `SCC_K285_POS : `SCC_K285_NEG))
		else $error("eof k28.5 form wrong");
	a_eof_next_lsb: assert property (s_sc(8'h22) ##1 s_dat ##0 (tx_data[4:0] == 5'h15 && tx_data[7:6] == 2'h2)
		|=> tx_char_r == ($past(tx_rd_r) ? 10'h2a2 : 10'h2aa))
		else $error("eof follower low bit wrong");
	a_negk_forced: assert property (s_sc(8'he1) |=> tx_char_r == `SCC_K285_NEG)
		else $error("forced negative k wrong");
	a_posk_forced: assert property (s_sc(8'he2) |=> tx_char_r == `SCC_K285_POS)
		else $error("forced positive k wrong");
	a_rdv_pattern: assert property (s_sc(8'he4) ##0 tx_encoded_mode && !tx_rd_r |=> tx_char_r == `SCC_RDV_RDM)
		else $error("violation pattern wrong");
	a_tx_rd_track: assert property ($past(rstn) && tx_char_r == `SCC_K285_POS |-> !tx_rd_r)
		else $error("encoder disparity wrong");
	// ============================================================
	// receive
	a_rx_negk_wrong: assert property (rx_valid && rx_char == `SCC_K285_NEG && rx_rd_r |=> rx_data_r == 8'he1)
		else $error("c1.7 not reported");
	a_rx_posk_wrong: assert property (rx_valid && rx_char == `SCC_K285_POS && !rx_rd_r |=> rx_data_r == 8'he2)
		else $error("c2.7 not reported");
	a_rx_hold: assert property (!rx_valid |=> !rx_valid_r && !rx_align_r && $stable(rx_data_r))
		else $error("receive output not held");
	a_align_pulse: assert property (rx_valid && framer_enable && rx_char == `SCC_K285_NEG |=> rx_align_r)
		else $error("align pulse missing");
	a_rx_rd_viol: assert property (rx_valid && rx_char == 10'h2a2 && !rx_rd_r
		|=> rx_data_r == `SCC_CODE_RDV && rx_status_r == `SCC_ST_RD_VIOL)
		else $error("disparity violation not reported");
endmodule // scc_codec_checker
bind scc_codec scc_codec_checker scc_codec_checker_inst (.clk_sys(clk_sys), .rstn(rstn), .tx_valid(tx_valid),
	.tx_special(tx_special), .tx_data(tx_data), .tx_encoded_mode(tx_encoded_mode), .tx_char_r(tx_char_r),
	.tx_rd_r(tx_rd_r), .rx_valid(rx_valid), .rx_char(rx_char), .decode_code_set_select(decode_code_set_select),
	.framer_enable(framer_enable), .rx_valid_r(rx_valid_r), .rx_data_r(rx_data_r), .rx_special_r(rx_special_r),
	.rx_status_r(rx_status_r), .rx_rd_r(rx_rd_r), .rx_align_r(rx_align_r));

// ===== tb/scc_host_model.sv
// host controller model driving the transmit side
`timescale 1ns/1ns
module scc_host_model (
	input wire clk_sys,
	output reg tx_valid,
	output reg tx_special,
	output reg [7:0] tx_data,
	output reg tx_encoded_mode
);
	reg last_c7_r;
	reg last_svs_r;
	initial begin
		tx_valid = 1'h0;
		tx_special = 1'h0;
		tx_data = 8'h00;
		tx_encoded_mode = 1'h0;
		last_c7_r = 1'h0;
		last_svs_r = 1'h0;
	end
	// ============================================================
	// one character per call, launched at the falling edge
	task put(input v, input s, input [7:0] d, input e);
		begin
			@(negedge clk_sys);
			// undefined special codes are never issued, fill goes out instead
			if (v && s && !(d <= 8'h0b || d[4:0] == 5'h1c || d == 8'hf7 || d == 8'hfb || d == 8'hfd ||
				d == 8'hfe || d == 8'h22 || d == 8'he0 || d == 8'he1 || d == 8'he2 || d == 8'he4))
				v = 1'h0;
			if (v && !s && ((last_c7_r && (d[4:0] == 5'h0b || d[4:0] == 5'h14)) || (last_svs_r && d[4:0] == 5'h0b)))
				v = 1'h0;
			tx_valid = v;
			tx_special = s;
			// idle data toggles so stale bytes never look valid
			tx_data = v ? d : ~tx_data;
			tx_encoded_mode = e;
			last_c7_r = v && s && (d == 8'h07 || d == 8'hfc);
			last_svs_r = v && s && d == 8'he0;
		end
	endtask
endmodule // scc_host_model

// ===== tb/tb_scc_codec.sv
// self-checking testbench for the special character codec
`timescale 1ns/1ns
`include "scc_codec_map.vh"
module tb_scc_codec;
	reg clk_sys = 1'h0;
	reg rstn = 1'h0;
	reg rx_valid = 1'h0;
	reg [9:0] rx_char = 10'h000;
	reg [1:0] decode_code_set_select = 2'h0;
	reg framer_enable = 1'h1;
	wire tx_valid, tx_special, tx_encoded_mode, tx_rd_r, rx_valid_r, rx_special_r, rx_rd_r, rx_align_r;
	wire [7:0] tx_data, rx_data_r;
	wire [9:0] tx_char_r;
	wire [2:0] rx_status_r;
	integer mismatches = 0;
	integer n_compared = 0;
	initial forever #4 clk_sys = ~clk_sys;
	scc_host_model scc_host_model_inst (.clk_sys(clk_sys), .tx_valid(tx_valid), .tx_special(tx_special),
		.tx_data(tx_data), .tx_encoded_mode(tx_encoded_mode));
	scc_codec scc_codec_inst (.clk_sys(clk_sys), .rstn(rstn), .tx_valid(tx_valid), .tx_special(tx_special),
		.tx_data(tx_data), .tx_encoded_mode(tx_encoded_mode), .tx_char_r(tx_char_r), .tx_rd_r(tx_rd_r),
		.rx_valid(rx_valid), .rx_char(rx_char), .decode_code_set_select(decode_code_set_select),
		.framer_enable(framer_enable), .rx_valid_r(rx_valid_r), .rx_data_r(rx_data_r), .rx_special_r(rx_special_r),
		.rx_status_r(rx_status_r), .rx_rd_r(rx_rd_r), .rx_align_r(rx_align_r));
	// ============================================================
	// shared tasks
	task chk(input string nm, input [9:0] exp, input [9:0] got);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("Error %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task close_out;
		begin
			$display("mismatches %0d compared %0d", mismatches, n_compared);
			if (mismatches == 0 && n_compared > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task rst(input integer n);
		begin
			@(negedge clk_sys);
			rstn = 1'h0;
			repeat (n) @(negedge clk_sys);
			chk("tx_char_r", `SCC_K285_NEG, tx_char_r);
			chk("tx_rd_r", 10'h000, {9'h000, tx_rd_r});
			chk("rx_rd_r", 10'h000, {9'h000, rx_rd_r});
			rstn = 1'h1;
		end
	endtask
	// one transmit character, checked after the edge that takes it
	task tx(input v, input s, input [7:0] d, input e, input [9:0] exp_c, input exp_rd);
		begin
			scc_host_model_inst.put(v, s, d, e);
			@(posedge clk_sys);
			#1;
			chk("tx_char_r", exp_c, tx_char_r);
			chk("tx_rd_r", {9'h000, exp_rd}, {9'h000, tx_rd_r});
		end
	endtask
	task rx(input [9:0] ch, input [7:0] exp_d, input [2:0] exp_st, input exp_rd);
		begin
			@(negedge clk_sys);
			rx_valid = 1'h1;
			rx_char = ch;
			@(posedge clk_sys);
			#1;
			chk("rx_valid_r", 10'h001, {9'h000, rx_valid_r});
			chk("rx_special_r", {9'h000, exp_st != `SCC_ST_DATA}, {9'h000, rx_special_r});
			chk("rx_data_r", {2'h0, exp_d}, {2'h0, rx_data_r});
			chk("rx_status_r", {7'h00, exp_st}, {7'h00, rx_status_r});
			chk("rx_rd_r", {9'h000, exp_rd}, {9'h000, rx_rd_r});
			chk("rx_align_r", {9'h000, framer_enable && (ch == `SCC_K285_NEG || ch == `SCC_K285_POS)}, {9'h000, rx_align_r});
		end
	endtask
	// ============================================================
	// scenarios
	task tx_specials;
		begin
			tx(1'h1, 1'h1, 8'he2, 1'h0, `SCC_K285_POS, 1'h0);
			tx(1'h1, 1'h1, 8'h22, 1'h0, `SCC_K285_NEG, 1'h1);
			tx(1'h1, 1'h0, 8'hb5, 1'h0, 10'h2a2, 1'h0);
			tx(1'h1, 1'h1, 8'he1, 1'h0, `SCC_K285_NEG, 1'h1);
			tx(1'h1, 1'h1, 8'h22, 1'h0, `SCC_K285_POS, 1'h0);
			tx(1'h1, 1'h0, 8'hb5, 1'h0, 10'h2aa, 1'h0);
			tx(1'h1, 1'h0, 8'hb5, 1'h0, 10'h2aa, 1'h0);
			tx(1'h1, 1'h1, 8'hbc, 1'h0, `SCC_K285_NEG, 1'h1);
			tx(1'h1, 1'h1, 8'h05, 1'h0, `SCC_K285_POS, 1'h0);
			tx(1'h0, 1'h0, 8'h00, 1'h0, `SCC_K285_NEG, 1'h1);
			// the host model turns the undefined code into fill
			tx(1'h1, 1'h1, 8'he3, 1'h0, `SCC_K285_POS, 1'h0);
			tx(1'h1, 1'h1, 8'he4, 1'h0, `SCC_K285_NEG, 1'h1);
			tx(1'h1, 1'h1, 8'he4, 1'h1, 10'h08a, 1'h0);
			tx(1'h1, 1'h1, 8'he4, 1'h1, `SCC_RDV_RDM, 1'h1);
		end
	endtask
	task rx_specials;
		begin
			rx(`SCC_K285_NEG, 8'h05, `SCC_ST_SPECIAL, 1'h1);
			rx(`SCC_K285_NEG, 8'he1, `SCC_ST_SPECIAL, 1'h1);
			rx(`SCC_K285_POS, 8'h05, `SCC_ST_SPECIAL, 1'h0);
			rx(`SCC_K285_POS, 8'he2, `SCC_ST_SPECIAL, 1'h0);
			rx(10'h2aa, 8'hb5, `SCC_ST_DATA, 1'h0);
			rx(10'h2a2, 8'he4, `SCC_ST_RD_VIOL, 1'h0);
			rx(10'h000, 8'he0, `SCC_ST_CODE_VIOL, 1'h0);
			@(negedge clk_sys);
			decode_code_set_select = 2'h1;
			framer_enable = 1'h0;
			rx(`SCC_K285_NEG, 8'hbc, `SCC_ST_SPECIAL, 1'h1);
			@(negedge clk_sys);
			rx_valid = 1'h0;
			rx_char = ~rx_char;
			repeat (2) @(negedge clk_sys);
			chk("rx_data_r", 10'h0bc, {2'h0, rx_data_r});
			chk("rx_valid_r", 10'h000, {9'h000, rx_valid_r});
			chk("rx_align_r", 10'h000, {9'h000, rx_align_r});
		end
	endtask
	initial begin
		#100000;
		mismatches = mismatches + 1;
		close_out;
	end
	initial begin
		rst(16);
		tx_specials;
		rst(2);
		rx_specials;
		close_out;
	end
endmodule // tb_scc_codec
